// [hdl/bkrc_top.sv]
// regulator control: enables, setpoint, slew, soft-start, protection
// How it works
// - register reads and writes work whenever reset is released, enable pin ignored
// - enable pin low never touches register contents
// - power-on reset returns every register, both settings included, to default
// - discharge path on when discharge bit set and enable or soft enable low
// - enable with selected soft enable starts soft-start, reference ramps up
// - synchronous rectification held off for whole soft-start
// - sixteen consecutive limit cycles tri-state stage, soft-start again 1700 us later
// - both soft enables come out of reset set
// - pin low means off; select pin picks soft enable and mode
// - light-load pulse mode allowed from mode bits and select pin level
// - target voltage is 0.600 V plus code times 6.25 mV
// - select pin low uses setting zero, high uses setting one
// - 3-bit slew code: 64 mV/us at 000, halving per step
// - falling setpoint after soft-start stops switching until output reaches new setpoint
// - undervoltage indication holds regulator inactive even with enable high
// - filtered overvoltage indication stops switching
// - setting register bit 7 soft enable, bits 6:0 voltage code
// - control register holds discharge enable and rising slew code
`timescale 1ns/1ps
`include "bkrc_defs.svh"
module bkrc_top
    import bkrc_pkg::*;
#(
    parameter logic [6:0] CODE0_RST = `BKRC_CODE_RST,
    parameter logic [6:0] CODE1_RST = `BKRC_CODE_RST,
    parameter int HICCUP_CYCLES =
        `BKRC_HICCUP_US * 1000 / `BKRC_CLK_NS,
    parameter int OVP_FILT_CYCLES =
        `BKRC_OVP_FILT_NS / `BKRC_CLK_NS,
    parameter int CL_LIMIT = `BKRC_CL_LIMIT
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic enPin,
    input wire logic output_select_pin,
    // register port from the serial engine
    input wire logic regWrEn,
    input wire logic [1:0] regWrAddr,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [1:0] regRdAddr,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // analog indications
    input wire logic uvloOk,
    input wire logic ovpRaw,
    input wire logic clCycleDone,
    input wire logic clHit,
    input wire logic voutAtTarget,
    // modulator and power stage
    output bkrc_stage_t stage,
    output logic [6:0] refCode,
    output logic [20:0] targetUv,
    output logic softStart
);
    localparam int FR = `BKRC_FRAC;
    localparam int AW = 7 + FR;
    localparam int HW = $clog2(HICCUP_CYCLES + 1);
    localparam int LW = $clog2(CL_LIMIT + 1);
    localparam longint INC_NUM = 64'(`BKRC_SLEW_MAX_UV_PER_US) *
        64'(`BKRC_CLK_NS) * (64'd1 << FR);
    localparam longint INC_DEN = 64'(`BKRC_STEP_UV) * 64'd1000;
    localparam logic [AW-1:0] SLEW_INC = AW'(INC_NUM / INC_DEN);

    if (HICCUP_CYCLES < 1 || OVP_FILT_CYCLES < 1 || CL_LIMIT < 2 ||
        (SLEW_INC >> 7) == '0) begin : g_bad
        $error("bkrc_top: parameter out of range");
    end

    // registers
    bkrc_setting_t set0_ff;
    bkrc_setting_t set1_ff;
    bkrc_ctrl_t ctrl_ff;
    logic [7:0] rdData_ff;
    logic rdValid_ff;

    // control state
    bkrc_state_t state_ff;
    bkrc_state_t nxt_state;
    logic [AW-1:0] refAcc_ff;
    logic [AW-1:0] nxt_refAcc;
    logic falling_ff;
    logic nxt_falling;
    logic [LW-1:0] clCount_ff;
    logic [LW-1:0] nxt_clCount;
    logic [HW-1:0] hiccup_ff;
    logic [HW-1:0] nxt_hiccup;

    // output flops
    bkrc_stage_t stage_ff;
    logic [6:0] refCode_ff;
    logic [20:0] targetUv_ff;
    logic softStart_ff;

    logic ovpFilt;

    // filtering ovp
    // noise filter
    bkrc_filter #(
        .CYCLES(OVP_FILT_CYCLES)
    ) u_ovp (
        .clk(clk),
        .rst_n(rst_n),
        .rawIn(ovpRaw),
        .filtOut(ovpFilt)
    );

    // register decode
    wire wrSet0 = regWrEn && regWrAddr == `BKRC_ADDR_SET0;
    wire wrSet1 = regWrEn && regWrAddr == `BKRC_ADDR_SET1;
    wire wrCtrl = regWrEn && regWrAddr == `BKRC_ADDR_CTRL;
    // spare control bits stay zero so reads show only live fields
    wire bkrc_ctrl_t ctrlWr = '{discharge: regWrData[7],
                                slew: regWrData[6:4],
                                spare: 2'h0,
                                mode: regWrData[1:0]};
    wire [7:0] statusWord = {1'b0, ovpFilt, falling_ff,
                             stage_ff.switchEn, 2'(state_ff),
                             uvloOk, enPin};
    wire [7:0] rdMux =
        (regRdAddr == `BKRC_ADDR_SET0) ? set0_ff :
        (regRdAddr == `BKRC_ADDR_SET1) ? set1_ff :
        (regRdAddr == `BKRC_ADDR_CTRL) ? ctrl_ff :
        statusWord;

    // selection of the active setting
    // pin picks setting
    wire bkrc_setting_t setSel = output_select_pin ? set1_ff : set0_ff;
    wire swEnSel = setSel.swEn;
    wire [6:0] codeSel = setSel.voltageCode;
    wire [AW-1:0] targetAcc = {codeSel, {FR{1'b0}}};

    // enable decision
    // pin and soft enable
    wire onReq = enPin && swEnSel && uvloOk;

    wire forcedPwm = output_select_pin ? ctrl_ff.mode[1] : ctrl_ff.mode[0];

    wire dischargeReq = ctrl_ff.discharge && (!enPin || !swEnSel);

    // ramp steps
    // rate halves per code
    wire [AW-1:0] slewInc = SLEW_INC >> ctrl_ff.slew;
    wire [AW-1:0] ssInc = SLEW_INC >> `BKRC_SS_SHIFT;
    wire [AW:0] rampSum = {1'b0, refAcc_ff} +
        {1'b0, (state_ff == ST_SOFT) ? ssInc : slewInc};
    wire reached = rampSum >= {1'b0, targetAcc};
    wire [AW-1:0] rampNext = reached ? targetAcc : rampSum[AW-1:0];
    wire goingUp = targetAcc > refAcc_ff;
    wire goingDown = targetAcc < refAcc_ff;

    // current-limit run detection
    wire clTrip = clCycleDone && clHit &&
        clCount_ff == LW'(CL_LIMIT - 1);
    wire active = state_ff == ST_SOFT || state_ff == ST_RUN;
    wire hiccupDone = hiccup_ff == HW'(HICCUP_CYCLES - 1);

    always_comb begin
        nxt_clCount = clCount_ff;
        if (!active || !onReq) begin
            nxt_clCount = '0;
        end else if (clCycleDone) begin
            nxt_clCount = clHit ? clCount_ff + 1'b1 : '0;
        end
    end

    // sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_refAcc = refAcc_ff;
        nxt_falling = falling_ff;
        nxt_hiccup = '0;
        case (state_ff)
            ST_OFF: begin
                nxt_falling = 1'b0;
                nxt_refAcc = '0;
                if (onReq) begin
                    nxt_state = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (!onReq) begin
                    nxt_state = ST_OFF;
                end else if (clTrip) begin
                    nxt_state = ST_HICCUP;
                end else begin
                    nxt_refAcc = rampNext;
                    if (reached) begin
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (!onReq) begin
                    nxt_state = ST_OFF;
                end else if (clTrip) begin
                    nxt_state = ST_HICCUP;
                    nxt_falling = 1'b0;
                end else if (falling_ff) begin
                    if (voutAtTarget) begin
                        nxt_falling = 1'b0;
                        nxt_refAcc = targetAcc;
                    end
                end else if (goingDown) begin
                    nxt_falling = 1'b1;
                end else if (goingUp) begin
                    nxt_refAcc = rampNext;
                end
            end
            ST_HICCUP: begin
                nxt_refAcc = '0;
                if (!onReq) begin
                    nxt_state = ST_OFF;
                end else if (hiccupDone) begin
                    nxt_state = ST_SOFT;
                end else begin
                    nxt_hiccup = hiccup_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    // stage drive
    // overvoltage blocks switching
    wire switchReq = active && !falling_ff && !ovpFilt;
    wire syncReq = switchReq && state_ff == ST_RUN;
    wire bkrc_stage_t nxt_stage = '{switchEn: switchReq,
                                    tristate: !switchReq,
                                    syncRectEn: syncReq,
                                    pfmAllowed: !forcedPwm,
                                    dischargeOn: dischargeReq};
    wire [20:0] nxt_targetUv = 21'(`BKRC_BASE_UV) +
        21'(refAcc_ff[AW-1:FR]) * 21'(`BKRC_STEP_UV);

    // registers keep values unless written; only rst_n resets them
    // enable pin not in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set0_ff <= '{swEn: `BKRC_SWEN_RST, voltageCode: CODE0_RST};
            set1_ff <= '{swEn: `BKRC_SWEN_RST, voltageCode: CODE1_RST};
            ctrl_ff <= `BKRC_CTRL_RST;
        end else begin
            if (wrSet0) begin
                set0_ff <= regWrData;
            end
            if (wrSet1) begin
                set1_ff <= regWrData;
            end
            if (wrCtrl) begin
                ctrl_ff <= ctrlWr;
            end
        end
    end

    // read answer one cycle after the strobe
    // read path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= `BKRC_ZERO8;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= regRdEn;
            if (regRdEn) begin
                rdData_ff <= rdMux;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_OFF;
            refAcc_ff <= '0;
            falling_ff <= 1'b0;
            clCount_ff <= '0;
            hiccup_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            refAcc_ff <= nxt_refAcc;
            falling_ff <= nxt_falling;
            clCount_ff <= nxt_clCount;
            hiccup_ff <= nxt_hiccup;
        end
    end

    // output flops; discharge and stage start safe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_ff <= '{switchEn: 1'b0, tristate: 1'b1,
                          syncRectEn: 1'b0, pfmAllowed: 1'b1,
                          dischargeOn: 1'b0};
            refCode_ff <= '0;
            targetUv_ff <= 21'(`BKRC_BASE_UV);
            softStart_ff <= 1'b0;
        end else begin
            stage_ff <= nxt_stage;
            refCode_ff <= refAcc_ff[AW-1:FR];
            targetUv_ff <= nxt_targetUv;
            softStart_ff <= state_ff == ST_SOFT;
        end
    end

    assign stage = stage_ff;
    assign refCode = refCode_ff;
    assign targetUv = targetUv_ff;
    assign softStart = softStart_ff;
    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;
endmodule

// [hdl/bkrc_defs.svh]
// constants for the regulator control logic
`ifndef BKRC_DEFS_SVH
`define BKRC_DEFS_SVH
// register offsets
`define BKRC_ADDR_SET0 2'h0
`define BKRC_ADDR_SET1 2'h1
`define BKRC_ADDR_CTRL 2'h2
`define BKRC_ADDR_STAT 2'h3
// reset values
`define BKRC_CTRL_RST 8'h82
`define BKRC_SWEN_RST 1'b1
`define BKRC_CODE_RST 7'h50
`define BKRC_ZERO8 8'h00
// voltage scale in microvolts
`define BKRC_BASE_UV 600000
`define BKRC_STEP_UV 6250
// clock and timing
`define BKRC_CLK_NS 10
`define BKRC_SLEW_MAX_UV_PER_US 64000
`define BKRC_FRAC 16
`define BKRC_SS_SHIFT 3'h2
`define BKRC_CL_LIMIT 16
`define BKRC_HICCUP_US 1700
`define BKRC_OVP_FILT_NS 500
`endif

// [hdl/bkrc_pkg.sv]
// types for the regulator control logic
package bkrc_pkg;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_SOFT,
        ST_RUN,
        ST_HICCUP
    } bkrc_state_t;

    // one voltage setting register
    typedef struct packed {
        logic swEn;
        logic [6:0] voltageCode;
    } bkrc_setting_t;

    // control register
    typedef struct packed {
        logic discharge;
        logic [2:0] slew;
        logic [1:0] spare;
        logic [1:0] mode;
    } bkrc_ctrl_t;

    // drive to the modulator and power stage
    typedef struct packed {
        logic switchEn;
        logic tristate;
        logic syncRectEn;
        logic pfmAllowed;
        logic dischargeOn;
    } bkrc_stage_t;
endpackage

// [hdl/bkrc_filter.sv]
// glitch filter: output follows input only after it stays put
`timescale 1ns/1ps
module bkrc_filter
    import bkrc_pkg::*;
#(
    parameter int CYCLES = 50
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw and filtered level
    input wire logic rawIn,
    output logic filtOut
);
    localparam int CW = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_bad
        $error("bkrc_filter: CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_ff;
    logic filt_ff;
    wire differs = rawIn != filt_ff;
    wire settled = cnt_ff == CW'(CYCLES - 1);
    wire [CW-1:0] nxt_cnt = (!differs || settled) ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            filt_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            if (differs && settled) begin
                filt_ff <= rawIn;
            end
        end
    end

    assign filtOut = filt_ff;
endmodule

// [tb/bkrc_top_properties.sv]
// port checker for the regulator control block
`timescale 1ns/1ps
module bkrc_top_properties
    import bkrc_pkg::*;
#(
    parameter int CL_LIMIT = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic enPin,
    input wire logic uvloOk,
    input wire logic regRdEn,
    input wire logic regRdValid,
    input wire logic clCycleDone,
    input wire logic clHit,
    input wire bkrc_stage_t stage,
    input wire logic [6:0] refCode,
    input wire logic [20:0] targetUv,
    input wire logic softStart
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // run of limit hits; cleared when switching stops, so it never overcounts
    logic [4:0] hitRun_ff;
    logic [4:0] nxt_hitRun;
    assign nxt_hitRun = (!stage.switchEn || hitRun_ff == 5'(CL_LIMIT)) ?
        5'h00 : !clCycleDone ? hitRun_ff : clHit ? hitRun_ff + 5'h01 : 5'h00;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hitRun_ff <= 5'h00;
        end else begin
            hitRun_ff <= nxt_hitRun;
        end
    end
    chk_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read strobe got no answer");
    chk_read_quiet: assert property (!regRdEn |=> !regRdValid)
        else $error("read answer without strobe");
    chk_pin_off: assert property (!enPin |-> ##2 !stage.switchEn)
        else $error("switching with enable pin low");
    chk_uvlo_hold: assert property (!uvloOk |-> ##2 !stage.switchEn)
        else $error("switching under undervoltage");
    chk_soft_norect: assert property (softStart |-> !stage.syncRectEn)
        else $error("rectifier on in soft-start");
    chk_target_scale: assert property (
        targetUv == 21'(600000 + 6250 * int'(refCode)))
        else $error("target voltage off scale");
    chk_hiccup_entry: assert property (
        hitRun_ff == 5'(CL_LIMIT) |=> stage.tristate && !stage.switchEn)
        else $error("no tri-state after limit run");
    chk_tri_idle: assert property (stage.tristate |-> !stage.switchEn)
        else $error("switching while tri-stated");
endmodule
bind bkrc_top bkrc_top_properties #(.CL_LIMIT(CL_LIMIT)) chk (
    .clk(clk), .rst_n(rst_n), .enPin(enPin), .uvloOk(uvloOk),
    .regRdEn(regRdEn), .regRdValid(regRdValid), .clCycleDone(clCycleDone),
    .clHit(clHit), .stage(stage), .refCode(refCode), .targetUv(targetUv),
    .softStart(softStart)
);

// [tb/bkrc_stage_model.sv]
// behavioural power stage: cycle ends, limit hits, output decay
`timescale 1ns/1ps
module bkrc_stage_model
    import bkrc_pkg::*;
#(
    parameter int PERIOD = 4,
    parameter int DECAY = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // drive from the block and overload request from the bench
    input wire bkrc_stage_t stage,
    input wire logic overload,
    // indications back
    output logic clCycleDone,
    output logic clHit,
    output logic voutAtTarget
);
    logic [3:0] phase_ff;
    logic [5:0] decay_ff;
    assign clHit = overload && clCycleDone;
    // output only sinks by load once switching has stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= 4'h0;
            decay_ff <= 6'h00;
            clCycleDone <= 1'b0;
            voutAtTarget <= 1'b0;
        end else begin
            phase_ff <= (phase_ff == 4'(PERIOD - 1)) ? 4'h0 : phase_ff + 4'h1;
            clCycleDone <= stage.switchEn && phase_ff == 4'h0;
            decay_ff <= stage.switchEn ? 6'h00 :
                decay_ff + 6'(decay_ff != 6'h3F);
            voutAtTarget <= !stage.switchEn && decay_ff >= 6'(DECAY);
        end
    end
endmodule

// [tb/tb_bkrc_top.sv]
// self-checking bench for the regulator control block
`timescale 1ns/1ps
module tb_bkrc_top;
    import bkrc_pkg::*;
    logic clk, rst_n, enPin, selPin, regWrEn, regRdEn, regRdValid;
    logic [1:0] regWrAddr, regRdAddr;
    logic [7:0] regWrData, regRdData;
    logic uvloOk, ovpRaw, clCycleDone, clHit, voutAtTarget, softStart, overload;
    bkrc_stage_t stage;
    logic [6:0] refCode;
    logic [20:0] targetUv;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    // short hiccup and filter keep the run brief
    bkrc_top #(.HICCUP_CYCLES(40), .OVP_FILT_CYCLES(3)) dut (
        .clk(clk), .rst_n(rst_n), .enPin(enPin), .output_select_pin(selPin),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdAddr(regRdAddr), .regRdData(regRdData),
        .regRdValid(regRdValid), .uvloOk(uvloOk), .ovpRaw(ovpRaw),
        .clCycleDone(clCycleDone), .clHit(clHit), .voutAtTarget(voutAtTarget),
        .stage(stage), .refCode(refCode), .targetUv(targetUv),
        .softStart(softStart));
    bkrc_stage_model model (
        .clk(clk), .rst_n(rst_n), .stage(stage), .overload(overload),
        .clCycleDone(clCycleDone), .clHit(clHit), .voutAtTarget(voutAtTarget));
    always #5 clk = ~clk;
    task automatic summarize();
        $display("checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what,
                seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regWrAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRdEn <= 1'b1;
        regRdAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check(regRdValid, 1'b1, "read valid");
        check(regRdData, exp, "read data");
    endtask
    // wait for regulation with rectifier on; the watchdog bounds it
    task automatic waitRun();
        do begin
            @(posedge clk);
            #1;
        end while (stage.syncRectEn !== 1'b1);
    endtask
    task automatic untilCode(input logic [6:0] c, output int k);
        k = 0;
        while (refCode !== c) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic hits(input int k);
        int seen;
        seen = 0;
        overload <= 1'b1;
        while (seen < k) begin
            @(posedge clk);
            if (clCycleDone === 1'b1) seen++;
        end
        overload <= 1'b0;
    endtask
    initial begin
        clk = 0; rst_n = 0; enPin = 0; selPin = 0; regWrEn = 0; regRdEn = 0;
        regWrAddr = 0; regRdAddr = 0; regWrData = 0; uvloOk = 1; ovpRaw = 0;
        overload = 0;
        cyc(8);
        rst_n <= 1'b1;
        cyc(3);
        rd(2'h0, 8'hD0);
        rd(2'h1, 8'hD0);
        rd(2'h2, 8'h82);
        check(stage.dischargeOn, 1'b1, "discharge off");
        check(stage.pfmAllowed, 1'b1, "pfm barred");
        wr(2'h0, 8'h8A);
        wr(2'h3, 8'h00);
        rd(2'h0, 8'h8A);
        $display("register defaults done");
        enPin <= 1'b1;
        cyc(3);
        #1;
        check(stage.switchEn, 1'b1, "not started");
        check(softStart, 1'b1, "no soft-start");
        check(stage.dischargeOn, 1'b0, "discharge on");
        waitRun();
        check(targetUv, 21'd662500, "target");
        @(posedge clk);
        enPin <= 1'b0;
        cyc(3);
        #1;
        check(stage.switchEn, 1'b0, "pin low on");
        rd(2'h0, 8'h8A);
        enPin <= 1'b1;
        waitRun();
        $display("enable and soft-start done");
        @(posedge clk);
        selPin <= 1'b1;
        untilCode(7'h50, n);
        check(stage.pfmAllowed, 1'b0, "pfm in forced");
        check(n >= 675 && n <= 695, 1'b1, "fast slew");
        wr(2'h2, 8'hF2);
        wr(2'h1, 8'hD2);
        untilCode(7'h52, n);
        check(n >= 2450 && n <= 2600, 1'b1, "slow slew");
        selPin <= 1'b0;
        cyc(3);
        #1;
        check(stage.switchEn, 1'b0, "falling switches");
        do @(posedge clk); while (stage.switchEn !== 1'b1);
        check(refCode, 7'h0A, "falling code");
        $display("select and slew done");
        wr(2'h0, 8'h0A);
        cyc(3);
        #1;
        check(stage.switchEn, 1'b0, "soft off");
        check(stage.dischargeOn, 1'b1, "no discharge");
        wr(2'h0, 8'h8A);
        waitRun();
        @(posedge clk);
        uvloOk <= 1'b0;
        cyc(3);
        #1;
        check(stage.switchEn, 1'b0, "uvlo on");
        @(posedge clk);
        uvloOk <= 1'b1;
        waitRun();
        @(posedge clk);
        ovpRaw <= 1'b1;
        @(posedge clk);
        ovpRaw <= 1'b0;
        cyc(6);
        #1;
        check(stage.switchEn, 1'b1, "spike stopped");
        @(posedge clk);
        ovpRaw <= 1'b1;
        cyc(10);
        #1;
        check(stage.switchEn, 1'b0, "ovp ignored");
        @(posedge clk);
        ovpRaw <= 1'b0;
        cyc(10);
        #1;
        check(stage.switchEn, 1'b1, "ovp stuck");
        $display("enables and protection done");
        hits(15);
        cyc(8);
        hits(15);
        cyc(3);
        #1;
        check(stage.tristate, 1'b0, "early hiccup");
        // one more hit makes the sixteenth; a second would only come after
        // the retry, when the stage is no longer tri-stated
        hits(1);
        cyc(3);
        #1;
        check(stage.tristate, 1'b1, "no hiccup");
        n = 0;
        while (stage.tristate === 1'b1) begin
            @(posedge clk);
            n++;
        end
        check(n >= 38 && n <= 41, 1'b1, "hiccup length");
        #1;
        check(softStart, 1'b1, "no restart");
        $display("current limit done");
        summarize();
    end
endmodule
